//--- rtl/pci_config_command_status.sv
/*
 * Configuration command and status logic of a PCI network
 * controller: identification, command register, status register
 * and the gates that the command bits put on the bus engines.
 * Assumes a dword-wide configuration port decoded by the target
 * engine, synchronous event inputs and the PCI clock as clock.
 */
// Contract
// [R1] Vendor code loads from EEPROM, else a fixed fallback.
// [R2] Device code loads from EEPROM, else a fixed fallback.
// [R3] Command register is 16 bits; bits 15..10 have no function.
// [R4] Fast back-to-back option clear: bit 9 reads 0, no such cycles.
// [R5] Option set: bit 9 writable, resets 0, 1 allows other agents.
// [R6] Bit 8 set: address parity error drives system error out.
// [R7] Bit 7 reads 0, writes ignored; no stepping.
// [R8] Bit 6 set: drive parity pin as target, sample it as master.
// [R9] Bit 6 clear: parity errors ignored; clear after reset.
// [R10] Bit 5 palette snoop reads 0, writes ignored.
// [R11] Bit 4 allows write-and-invalidate, else plain write; resets 0.
// [R12] Bit 3 reads 0, writes ignored; special cycles disregarded.
// [R13] Master transactions only while bit 2 is set.
// [R14] Firmware sets bit 2 before normal operation.
// [R15] Memory accesses claimed only while bit 1 is set.
// [R16] I/O accesses claimed only while bit 0 is set.
// [R17] Status reads normally; writes only clear, never set.
// [R18] Writing 1 clears a status bit; writing 0 leaves it.
// [R19] Reserved command bits read 0; writes discarded.
`timescale 1ns/1ps
`include "cfg_regs.svh"
module pci_config_command_status (
   input  wire logic             clock,
   input  wire logic             rstn,
   input  wire logic             cfg_rd,
   input  wire logic             cfg_wr,
   input  wire logic [5:0]       cfg_dw,
   input  wire logic [3:0]       cfg_be,
   input  wire logic [31:0]      cfg_wdata,
   output logic [31:0]           cfg_rdata,
   output logic                  cfg_ack,
   input  wire logic             eeprom_present,
   input  wire logic             eeprom_done,
   input  wire cfg_pkg::word16_t eeprom_vendor,
   input  wire cfg_pkg::word16_t eeprom_device,
   input  wire logic             fbb_option,
   input  wire logic             pm_option,
   input  wire logic             addr_parity_err,
   input  wire logic             target_parity_err,
   input  wire logic             master_active,
   input  wire logic             master_abort_rx,
   input  wire logic             target_abort_rx,
   input  wire logic             target_abort_tx,
   input  wire logic             mwi_request,
   input  wire logic             parity_error_pin_i,
   output logic                  parity_error_pin_o,
   output logic                  parity_error_pin_oe,
   output logic                  system_error_out_n,
   output logic                  system_error_oe,
   output logic                  memory_claim_ok,
   output logic                  io_claim_ok,
   output logic                  master_ok,
   output logic                  write_invalidate_use,
   output logic                  fast_b2b_same_ok,
   output logic                  fast_b2b_diff_ok
);
   // ***********************************************************
   // Identification and status submodules
   // ***********************************************************
   cfg_pkg::word16_t vendor_ident;
   cfg_pkg::word16_t device_ident;
   status_evt_if     evt ();

   ident_loader u_ident (
      .clock          (clock),
      .rstn           (rstn),
      .eeprom_present (eeprom_present),
      .eeprom_done    (eeprom_done),
      .eeprom_vendor  (eeprom_vendor),
      .eeprom_device  (eeprom_device),
      .vendor_ident   (vendor_ident),
      .device_ident   (device_ident)
   );

   status_reg u_status (
      .clock (clock),
      .rstn  (rstn),
      .evt   (evt)
   );

   // ***********************************************************
   // Command register
   // ***********************************************************
   cfg_pkg::word16_t cmd_q, cmd_d, cmd_mask, cmd_view;
   logic             cmd_hit;

   assign cmd_hit = cfg_wr && (cfg_dw == `DW_CMD_STATUS);

   // Only implemented bits store; bit 9 only with the option set
   always_comb
   begin
      cmd_mask = `CMD_RW_MASK;                    // see [R19]
      cmd_mask[`CMD_FBB] = fbb_option;            // see [R5]
      cmd_d = cmd_q;
      if (cmd_hit && cfg_be[0])
         cmd_d[7:0] = cfg_wdata[7:0];
      if (cmd_hit && cfg_be[1])
         cmd_d[15:8] = cfg_wdata[15:8];
      cmd_d = cmd_d & cmd_mask;                   // see [R3]
   end

   // Reset clears all, so parity response and mastering start off
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         cmd_q <= `CMD_RESET;                     // see [R9]
      else
         cmd_q <= cmd_d;
   end

   // Read view masks bit 9 live, so a dropped option hides it at once
   always_comb
   begin
      cmd_view = cmd_q & cmd_mask;
      cmd_view[`CMD_STEP] = 1'b0;                 // see [R7]
      cmd_view[`CMD_SNOOP] = 1'b0;                // see [R10]
      cmd_view[`CMD_SPECIAL] = 1'b0;              // see [R12]
   end

   // ***********************************************************
   // Gates towards the bus engines
   // ***********************************************************
   // Combinational so a cleared enable takes hold the next cycle
   always_comb
   begin
      memory_claim_ok = cmd_view[`CMD_MEM];       // see [R15]
      io_claim_ok = cmd_view[`CMD_IO];            // see [R16]
      master_ok = cmd_view[`CMD_MASTER];          // see [R13]
      write_invalidate_use = master_ok && mwi_request
                             && cmd_view[`CMD_MWI]; // see [R11]
      fast_b2b_same_ok = fbb_option && master_ok;   // see [R4]
      fast_b2b_diff_ok = fast_b2b_same_ok
                         && cmd_view[`CMD_FBB];     // see [R5]
   end

   // ***********************************************************
   // Parity and system error pins
   // ***********************************************************
   logic perr_drive_q, perr_drive_d;
   logic serr_q, serr_d;
   logic master_perr_seen;

   // Pin is active low; sampling as master only counts in the data
   // phase the master engine reports as its own
   assign master_perr_seen = master_active && !parity_error_pin_i
                             && cmd_view[`CMD_PERR];     // see [R8]

   always_comb
   begin
      perr_drive_d = target_parity_err
                     && cmd_view[`CMD_PERR];           // see [R9]
      serr_d = addr_parity_err && cmd_view[`CMD_SERR]; // see [R6]
   end

   // Pin drives are registered so they never glitch mid-cycle
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         perr_drive_q <= 1'b0;
         serr_q <= 1'b0;
      end
      else
      begin
         perr_drive_q <= perr_drive_d;
         serr_q <= serr_d;
      end
   end

   // Open drain: the pins only ever pull low, never drive high
   assign parity_error_pin_o = 1'b0;              // Open-drain low
   assign parity_error_pin_oe = perr_drive_q;     // see [R8]
   assign system_error_out_n = !serr_q;           // see [R6]
   assign system_error_oe = serr_q;

   // ***********************************************************
   // Status events and write clears
   // ***********************************************************
   // Detected parity is recorded even with the response disabled
   always_comb
   begin
      evt.det_parity = addr_parity_err || target_parity_err
                       || (master_active && !parity_error_pin_i);
      evt.sig_serr = serr_q;
      evt.master_abt = master_abort_rx;
      evt.target_rx = target_abort_rx;
      evt.target_tx = target_abort_tx;
      evt.data_parity = master_perr_seen
                        || (master_active && perr_drive_q);
      evt.wr_clear = cmd_hit;
      evt.clear_mask = {cfg_be[3] ? cfg_wdata[31:24] : 8'h00,
                        cfg_be[2] ? cfg_wdata[23:16] : 8'h00}; // see [R18]
      evt.fbb_option = fbb_option;
      evt.pm_option = pm_option;
   end

   // ***********************************************************
   // Configuration read port
   // ***********************************************************
   logic [31:0] rdata_q, rdata_d;
   logic        ack_q, ack_d;

   // Read data registered; unmapped dwords read zero
   always_comb
   begin
      ack_d = cfg_rd || cfg_wr;
      rdata_d = rdata_q;
      if (cfg_rd)
      begin
         case (cfg_dw)
            `DW_IDENT:      rdata_d = {device_ident, vendor_ident};
            `DW_CMD_STATUS: rdata_d = {evt.value, cmd_view}; // see [R17]
            default:        rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // Ack is a plain pulse; a requester never waits more than one cycle
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         rdata_q <= 32'h0000_0000;
         ack_q <= 1'b0;
      end
      else
      begin
         rdata_q <= rdata_d;
         ack_q <= ack_d;
      end
   end

   assign cfg_rdata = rdata_q;
   assign cfg_ack = ack_q;

   // ***********************************************************
   // Checks
   // ***********************************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   a_cmd_reserved: assert property (              // see [R19]
      cfg_rd && cfg_dw == `DW_CMD_STATUS
      |=> cfg_rdata[15:10] == 6'h00 && cfg_rdata[7] == 1'b0
          && cfg_rdata[5] == 1'b0 && cfg_rdata[3] == 1'b0)
      else $error("reserved command bits read nonzero");
   a_fbb_off: assert property (                    // see [R4]
      !fbb_option |-> !fast_b2b_same_ok && !fast_b2b_diff_ok
                      && !cmd_view[`CMD_FBB])
      else $error("fast back-to-back without option");
   a_serr_gate: assert property (                  // see [R6]
      addr_parity_err |=> system_error_oe
                          == $past(cmd_view[`CMD_SERR]))
      else $error("system error pin not gated by enable");
   a_perr_gate: assert property (                  // see [R8]
      target_parity_err ##1 !target_parity_err
      |-> parity_error_pin_oe == $past(cmd_view[`CMD_PERR])
      ##1 !parity_error_pin_oe)
      else $error("parity pin drive wrong");
   a_io_write: assert property (                   // see [R16]
      cmd_hit && cfg_be[0]
      |=> io_claim_ok == $past(cfg_wdata[`CMD_IO])
          && memory_claim_ok == $past(cfg_wdata[`CMD_MEM]))
      else $error("space enables not written");
   a_master_gate: assert property (                // see [R13]
      !master_ok |-> !write_invalidate_use && !fast_b2b_same_ok)
      else $error("master activity while disabled");
   a_mwi_gate: assert property (                   // see [R11]
      mwi_request && master_ok
      |-> write_invalidate_use == cmd_q[`CMD_MWI])
      else $error("write-and-invalidate gate wrong");
   a_cmd_hold: assert property (                   // see [R3]
      !cmd_hit |=> cmd_q == ($past(cmd_q) & $past(cmd_mask)))
      else $error("command register changed without write");
   // Fixed bits, disabled responses and event recording
   a_cmd_fixed: assert property (                  // see [R7] [R10]
      !cmd_q[`CMD_STEP] && !cmd_q[`CMD_SNOOP]
      && !cmd_q[`CMD_SPECIAL] && cmd_q[15:10] == 6'h00)
      else $error("fixed command bit stored");
   a_perr_ignore: assert property (                // see [R9]
      !cmd_view[`CMD_PERR]
      |-> !master_perr_seen ##1 !parity_error_pin_oe)
      else $error("parity error acted on while disabled");
   a_b2b_diff: assert property (                   // see [R5]
      fast_b2b_diff_ok |-> fbb_option && cmd_q[`CMD_FBB])
      else $error("different-agent fast back-to-back not enabled");
   a_serr_record: assert property (                // see [R6]
      system_error_oe |=> evt.value[`ST_SIG_SERR])
      else $error("signalled system error not recorded");

   c_serr_fire: cover property (addr_parity_err ##1 system_error_oe);
   c_perr_fire: cover property (target_parity_err ##1
                                parity_error_pin_oe);
   c_master_on: cover property (!master_ok ##1 master_ok);
endmodule // pci_config_command_status

//--- include/cfg_regs.svh
/*
 * Constants of the configuration command and status block.
 * Assumes the configuration port addresses whole dwords.
 */
`ifndef CFG_REGS_SVH
`define CFG_REGS_SVH
// ***********************************************************
// Dword indices of the configuration port
// ***********************************************************
`define DW_IDENT        6'h00
`define DW_CMD_STATUS   6'h01
// ***********************************************************
// Command bit positions
// ***********************************************************
`define CMD_IO          0
`define CMD_MEM         1
`define CMD_MASTER      2
`define CMD_SPECIAL     3
`define CMD_MWI         4
`define CMD_SNOOP       5
`define CMD_PERR        6
`define CMD_STEP        7
`define CMD_SERR        8
`define CMD_FBB         9
`define CMD_RESET       16'h0000
`define CMD_RW_MASK     16'h0157
// ***********************************************************
// Status bit positions and fixed fields
// ***********************************************************
`define ST_DET_PARITY   15
`define ST_SIG_SERR     14
`define ST_MASTER_ABT   13
`define ST_TARGET_RX    12
`define ST_TARGET_TX    11
`define ST_DATA_PARITY  8
`define ST_FBB_CAP      7
`define ST_66MHZ        5
`define ST_NEW_CAP      4
`define ST_DEVSEL_MED   2'h1
`define ST_RESET        16'h0000
`endif

//--- include/cfg_pkg.sv
/*
 * Types shared by the configuration block modules.
 * Assumes nothing of its surroundings.
 */
package cfg_pkg;
   typedef logic [15:0] word16_t;
   typedef enum logic {ident_default, ident_loaded} ident_src_t;
endpackage

//--- include/status_evt_if.sv
/*
 * Carries status events, write clears and read-back between the
 * main block and the status register.
 * Assumes one clock for both ends.
 */
`timescale 1ns/1ps
interface status_evt_if;
   logic              det_parity;
   logic              sig_serr;
   logic              master_abt;
   logic              target_rx;
   logic              target_tx;
   logic              data_parity;
   logic              wr_clear;
   cfg_pkg::word16_t  clear_mask;
   logic              fbb_option;
   logic              pm_option;
   cfg_pkg::word16_t  value;
   modport main (output det_parity, sig_serr, master_abt, target_rx,
                 target_tx, data_parity, wr_clear, clear_mask,
                 fbb_option, pm_option, input value);
   modport status (input det_parity, sig_serr, master_abt, target_rx,
                   target_tx, data_parity, wr_clear, clear_mask,
                   fbb_option, pm_option, output value);
endinterface

//--- rtl/ident_loader.sv
/*
 * Holds vendor and device identification words, loaded from the
 * serial EEPROM reader or left at fallback values.
 * Assumes the reader pulses eeprom_done once its words are valid.
 */
`timescale 1ns/1ps
module ident_loader #(
   // Arbitrary neutral fallback codes
   parameter cfg_pkg::word16_t VENDOR_DEFAULT = 16'h1234,
   parameter cfg_pkg::word16_t DEVICE_DEFAULT = 16'h5678
) (
   input  wire logic             clock,
   input  wire logic             rstn,
   input  wire logic             eeprom_present,
   input  wire logic             eeprom_done,
   input  wire cfg_pkg::word16_t eeprom_vendor,
   input  wire cfg_pkg::word16_t eeprom_device,
   output cfg_pkg::word16_t      vendor_ident,
   output cfg_pkg::word16_t      device_ident
);
   cfg_pkg::ident_src_t src_q, src_d;
   cfg_pkg::word16_t    ven_q, ven_d, dev_q, dev_d;

   // Load once each time the part is present and done; a missing part forces the fallbacks
   always_comb
   begin
      src_d = src_q;
      ven_d = ven_q;
      dev_d = dev_q;
      case (src_q)
         cfg_pkg::ident_default:
            if (eeprom_present && eeprom_done)
            begin
               src_d = cfg_pkg::ident_loaded;
               ven_d = eeprom_vendor;    // see [R1]
               dev_d = eeprom_device;    // see [R2]
            end
         cfg_pkg::ident_loaded:
            if (!eeprom_present)
            begin
               src_d = cfg_pkg::ident_default;
               ven_d = VENDOR_DEFAULT;   // see [R1]
               dev_d = DEVICE_DEFAULT;   // see [R2]
            end
         default: src_d = cfg_pkg::ident_default;
      endcase
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         src_q <= cfg_pkg::ident_default;
         ven_q <= VENDOR_DEFAULT;
         dev_q <= DEVICE_DEFAULT;
      end
      else
      begin
         src_q <= src_d;
         ven_q <= ven_d;
         dev_q <= dev_d;
      end
   end

   assign vendor_ident = ven_q;
   assign device_ident = dev_q;

   a_ident_fallback: assert property (               // see [R1]
      @(posedge clock) disable iff (!rstn)
      !eeprom_present |=> vendor_ident == VENDOR_DEFAULT
                          && device_ident == DEVICE_DEFAULT)
      else $error("ident not at fallback without eeprom");
   a_ident_loads: assert property (                  // see [R2]
      @(posedge clock) disable iff (!rstn)
      src_q == cfg_pkg::ident_default && eeprom_present && eeprom_done
      |=> vendor_ident == $past(eeprom_vendor)
          && device_ident == $past(eeprom_device))
      else $error("ident not loaded from eeprom");
   c_ident_load: cover property (@(posedge clock) disable iff (!rstn)
      src_q == cfg_pkg::ident_loaded);
endmodule // ident_loader

//--- rtl/status_reg.sv
/*
 * Status register: sticky event bits cleared by writing ones,
 * fixed capability fields.
 * Assumes event inputs are one-cycle pulses or levels.
 */
`timescale 1ns/1ps
`include "cfg_regs.svh"
module status_reg (
   input  wire logic   clock,
   input  wire logic   rstn,
   status_evt_if.status evt
);
   cfg_pkg::word16_t sticky_q, sticky_d, set_v;

   // Set wins over a clear in the same cycle, so no event is lost
   always_comb
   begin
      set_v = '0;
      set_v[`ST_DET_PARITY]  = evt.det_parity;
      set_v[`ST_SIG_SERR]    = evt.sig_serr;
      set_v[`ST_MASTER_ABT]  = evt.master_abt;
      set_v[`ST_TARGET_RX]   = evt.target_rx;
      set_v[`ST_TARGET_TX]   = evt.target_tx;
      set_v[`ST_DATA_PARITY] = evt.data_parity;
      sticky_d = sticky_q;
      if (evt.wr_clear)
         sticky_d = sticky_q & ~evt.clear_mask;   // see [R18]
      sticky_d = sticky_d | set_v;                // see [R17]
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         sticky_q <= `ST_RESET;
      else
         sticky_q <= sticky_d;
   end

   // Fixed fields ride on top of the sticky bits
   always_comb
   begin
      evt.value = sticky_q;
      evt.value[10:9] = `ST_DEVSEL_MED;
      evt.value[`ST_FBB_CAP] = evt.fbb_option;
      evt.value[`ST_66MHZ] = 1'b1;
      evt.value[`ST_NEW_CAP] = evt.pm_option;
   end

   a_status_no_set: assert property (                // see [R17]
      @(posedge clock) disable iff (!rstn)
      !sticky_q[`ST_MASTER_ABT] && !evt.master_abt
      |=> !sticky_q[`ST_MASTER_ABT])
      else $error("status bit set without event");
   a_status_w1c: assert property (                   // see [R18]
      @(posedge clock) disable iff (!rstn)
      evt.wr_clear && evt.clear_mask[`ST_SIG_SERR] && !evt.sig_serr
      |=> !sticky_q[`ST_SIG_SERR])
      else $error("write of one did not clear");
   a_status_keep: assert property (                  // see [R18]
      @(posedge clock) disable iff (!rstn)
      evt.wr_clear && !evt.clear_mask[`ST_TARGET_TX]
      |=> sticky_q[`ST_TARGET_TX] == $past(sticky_q[`ST_TARGET_TX])
          || $past(evt.target_tx))
      else $error("write of zero changed status");
   c_status_race: cover property (@(posedge clock) disable iff (!rstn)
      evt.wr_clear && evt.clear_mask[`ST_SIG_SERR] && evt.sig_serr);
endmodule // status_reg

//--- testbench/bus_agent_model.sv
/*
 * Another agent on the shared parity error line: it pulls the
 * open-drain line low on request and resolves the wire level.
 * Assumes the bench raises pull_req just after a rising edge.
 */
`timescale 1ns/1ps
module bus_agent_model (
   input  wire logic clock,
   input  wire logic rstn,
   input  wire logic dut_oe,
   input  wire logic pull_req,
   output logic      pin_level
);
   logic pull_q;
   logic pull_d;

   // ***********************************************************
   // Pull request, registered like a real agent's output stage
   // ***********************************************************
   always_comb
   begin
      pull_d = pull_req;
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         pull_q <= 1'b0;
      else
         pull_q <= pull_d;
   end

   // Open drain with pull-up: low while any party drives it
   assign pin_level = ~(dut_oe | pull_q);
endmodule // bus_agent_model

//--- testbench/tb.sv
/*
 * Self-checking bench of the configuration command and status
 * block, driven through its dword configuration port.
 * Assumes the fallback codes and fixed status fields of the design.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
   err_count++; $display("unexpected at %0t: got %h exp %h", \
   $time, (a), (e)); end end
module tb;
   logic clock = 0, rstn = 0, cfg_rd = 0, cfg_wr = 0;
   logic [5:0] cfg_dw = '0;
   logic [3:0] cfg_be = '0;
   logic [31:0] cfg_wdata = '0, cfg_rdata, d;
   logic cfg_ack, e_pres = 0, e_done = 0, fbb = 0, apar = 0;
   logic tpar = 0, mact = 0, mabt = 0, tabr = 0, tabt = 0, mwi = 0;
   logic pull = 0, pin, poe, serr_n, serr_oe, mem_ok, io_ok, m_ok;
   logic wi_use, same_ok, diff_ok, po;
   cfg_pkg::word16_t e_ven = 16'h0abc, e_dev = 16'h0def;
   int err_count = 0, total_checks = 0, cycles = 0, i;

   pci_config_command_status u_dut (.clock(clock), .rstn(rstn),
      .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_dw(cfg_dw),
      .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .cfg_ack(cfg_ack), .eeprom_present(e_pres),
      .eeprom_done(e_done), .eeprom_vendor(e_ven),
      .eeprom_device(e_dev), .fbb_option(fbb), .pm_option(1'b0),
      .addr_parity_err(apar), .target_parity_err(tpar),
      .master_active(mact), .master_abort_rx(mabt),
      .target_abort_rx(tabr), .target_abort_tx(tabt),
      .mwi_request(mwi), .parity_error_pin_i(pin),
      .parity_error_pin_o(po), .parity_error_pin_oe(poe),
      .system_error_out_n(serr_n), .system_error_oe(serr_oe),
      .memory_claim_ok(mem_ok), .io_claim_ok(io_ok),
      .master_ok(m_ok), .write_invalidate_use(wi_use),
      .fast_b2b_same_ok(same_ok), .fast_b2b_diff_ok(diff_ok));

   bus_agent_model u_agent (.clock(clock), .rstn(rstn),
      .dut_oe(poe), .pull_req(pull), .pin_level(pin));

   // ***********************************************************
   // Clock, timeout and closing report
   // ***********************************************************
   initial
   begin
      forever #50 clock = ~clock;
   end

   // Ceiling well above the hundred-odd cycles the tests need
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_count++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ***********************************************************
   // Configuration port tasks: one request, answer a cycle later
   // ***********************************************************
   task automatic wr(input logic [5:0] dw, input logic [3:0] be,
                     input logic [31:0] v);
      @(posedge clock);
      cfg_wr <= 1'b1;
      cfg_dw <= dw;
      cfg_be <= be;
      cfg_wdata <= v;
      @(posedge clock);
      cfg_wr <= 1'b0;
      #1 `CHK(cfg_ack, 1'b1)
   endtask

   task automatic rd(input logic [5:0] dw, output logic [31:0] v);
      @(posedge clock);
      cfg_rd <= 1'b1;
      cfg_dw <= dw;
      @(posedge clock);
      cfg_rd <= 1'b0;
      #1 v = cfg_rdata;
      `CHK(cfg_ack, 1'b1)
   endtask

   // Status clear through the upper bytes; command bytes untouched
   task automatic clr();
      wr(6'h01, 4'hc, 32'hffff_0000);
   endtask

   // ***********************************************************
   // Main sequence
   // ***********************************************************
   initial
   begin
      repeat (12) @(posedge clock);
      rstn <= 1'b1;
      rd(6'h00, d);
      `CHK(d, 32'h5678_1234)
      rd(6'h01, d);
      `CHK(d, 32'h0220_0000)
      rd(6'h05, d);
      `CHK(d, 32'h0000_0000)
      // Only the implemented bits stick, option clear
      wr(6'h01, 4'h3, 32'h0000_ffff);
      rd(6'h01, d);
      `CHK(d[15:0], 16'h0157)
      `CHK(same_ok, 1'b0)
      @(posedge clock) fbb <= 1'b1;
      wr(6'h01, 4'h3, 32'h0000_ffff);
      rd(6'h01, d);
      `CHK(d, 32'h02a0_0357)
      `CHK(diff_ok, 1'b1)
      wr(6'h01, 4'h3, 32'h0000_0004);
      `CHK({same_ok, diff_ok}, 2'b10)
      // Each decode gate follows its own command bit
      for (i = 0; i < 8; i++)
      begin
         wr(6'h01, 4'h3, i);
         `CHK({m_ok, mem_ok, io_ok}, i[2:0])
      end
      @(posedge clock) mwi <= 1'b1;
      wr(6'h01, 4'h3, 32'h0000_0014);
      `CHK(wi_use, 1'b1)
      wr(6'h01, 4'h3, 32'h0000_0004);
      `CHK(wi_use, 1'b0)
      // Address parity error with and without the enable
      wr(6'h01, 4'h3, 32'h0000_0100);
      @(posedge clock) apar <= 1'b1;
      @(posedge clock) apar <= 1'b0;
      #1 `CHK({serr_oe, serr_n}, 2'b10)
      wr(6'h01, 4'h3, 32'h0000_0000);
      @(posedge clock) apar <= 1'b1;
      @(posedge clock) apar <= 1'b0;
      #1 `CHK(serr_oe, 1'b0)
      rd(6'h01, d);
      `CHK(d[30], 1'b1)
      wr(6'h01, 4'hc, 32'h0000_0000);
      rd(6'h01, d);
      `CHK(d[30], 1'b1)
      clr();
      rd(6'h01, d);
      `CHK(d, 32'h02a0_0000)
      // Target data parity error drives the pin only when enabled
      for (i = 0; i < 2; i++)
      begin
         wr(6'h01, 4'h3, i ? 32'h0000_0000 : 32'h0000_0040);
         @(posedge clock) tpar <= 1'b1;
         @(posedge clock) tpar <= 1'b0;
         #1 `CHK(poe, i ? 1'b0 : 1'b1)
         `CHK(po, 1'b0)
      end
      // Master sees another agent pull the pin
      for (i = 0; i < 2; i++)
      begin
         clr();
         wr(6'h01, 4'h3, i ? 32'h0000_0004 : 32'h0000_0044);
         @(posedge clock);
         mact <= 1'b1;
         pull <= 1'b1;
         repeat (2) @(posedge clock);
         mact <= 1'b0;
         pull <= 1'b0;
         rd(6'h01, d);
         `CHK(d[24], i ? 1'b0 : 1'b1)
      end
      // Abort events land in their own sticky bits
      clr();
      @(posedge clock);
      mabt <= 1'b1;
      tabr <= 1'b1;
      @(posedge clock);
      mabt <= 1'b0;
      tabr <= 1'b0;
      @(posedge clock) tabt <= 1'b1;
      @(posedge clock) tabt <= 1'b0;
      rd(6'h01, d);
      `CHK(d[31:16], 16'h3aa0)
      clr();
      rd(6'h01, d);
      `CHK(d[31:16], 16'h02a0)
      // Identification loaded from the serial memory, then fallback
      @(posedge clock) e_pres <= 1'b1;
      @(posedge clock) e_done <= 1'b1;
      @(posedge clock) e_done <= 1'b0;
      rd(6'h00, d);
      `CHK(d, 32'h0def_0abc)
      @(posedge clock) e_pres <= 1'b0;
      @(posedge clock);
      rd(6'h00, d);
      `CHK(d, 32'h5678_1234)
      end_sim();
   end
endmodule // tb
